// [hw/t8wm_pkg.sv]
package t8wm_pkg;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  // register offsets
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_CLKSEL = 3'h1;
  localparam logic [2:0] ADDR_COUNT = 3'h2;
  localparam logic [2:0] ADDR_CMP_A = 3'h3;
  localparam logic [2:0] ADDR_CMP_B = 3'h4;
  localparam logic [2:0] ADDR_FLAGS = 3'h5;
  localparam logic [2:0] ADDR_PIN_DIR = 3'h6;
  localparam logic [2:0] ADDR_PIN_DATA = 3'h7;
  // control field positions
  localparam int ACT_A_LSB = 6;
  localparam int ACT_B_LSB = 4;
  localparam int SEL_TOP_BIT = 3;
  localparam int SEL_LO_LSB = 0;
  // flag bit positions
  localparam int FLAG_OVF = 0;
  localparam int FLAG_MA = 1;
  localparam int FLAG_MB = 2;
  // waveform select values
  localparam logic [2:0] WS_NORMAL = 3'h0;
  localparam logic [2:0] WS_PC_FF = 3'h1;
  localparam logic [2:0] WS_CLEAR_CMP = 3'h2;
  localparam logic [2:0] WS_FAST_FF = 3'h3;
  localparam logic [2:0] WS_PC_CMP = 3'h5;
  localparam logic [2:0] WS_FAST_CMP = 3'h7;
  // output action values
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // prescale selections and divide masks (factor minus one)
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] MASK_DIV8 = 10'h007;
  localparam logic [9:0] MASK_DIV64 = 10'h03f;
  localparam logic [9:0] MASK_DIV256 = 10'h0ff;
  localparam logic [9:0] MASK_DIV1024 = 10'h3ff;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } t8wm_bus_t;
  typedef struct packed {
    logic o;
    logic oe;
  } t8wm_pin_t;
endpackage : t8wm_pkg

// [hw/t8wm_presc.sv]
`timescale 1ns/1ps
module t8wm_presc (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // selection and tick
  input wire logic [2:0] sel,
  output logic tick
);
  logic [9:0] div_r;
  logic [9:0] mask;
  logic hit;
  assign mask = (sel == t8wm_pkg::CS_DIV8) ? t8wm_pkg::MASK_DIV8 :
                (sel == t8wm_pkg::CS_DIV64) ? t8wm_pkg::MASK_DIV64 :
                (sel == t8wm_pkg::CS_DIV256) ? t8wm_pkg::MASK_DIV256 :
                t8wm_pkg::MASK_DIV1024;
  // select 0 and undefined codes stop the timer
  assign hit = (sel == t8wm_pkg::CS_DIV1) ||
               ((sel >= t8wm_pkg::CS_DIV8) && (sel <= t8wm_pkg::CS_DIV1024) &&
                ((div_r & mask) == mask));
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_r <= 10'h000;
      tick <= 1'b0;
    end else begin
      div_r <= div_r + 10'h001;
      tick <= hit;
    end
  end
endmodule : t8wm_presc

// [hw/t8wm_core.sv]
`timescale 1ns/1ps
module t8wm_core (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire t8wm_pkg::t8wm_bus_t bus,
  output logic [7:0] rdata,
  // waveform pins
  output t8wm_pkg::t8wm_pin_t pin_a,
  output t8wm_pkg::t8wm_pin_t pin_b,
  // flag levels
  output logic overflow_flag,
  output logic match_a_flag,
  output logic match_b_flag
);
  logic [7:0] ctrl_r;
  logic [2:0] clksel_r;
  logic [7:0] count_value_r;
  logic [7:0] count_value_nxt;
  logic [7:0] buf_a_r;
  logic [7:0] buf_b_r;
  logic [7:0] ocr_a_r;
  logic [7:0] ocr_b_r;
  logic [1:0] dir_r;
  logic [1:0] port_r;
  logic up_r;
  logic up_nxt;
  logic blk_r;
  logic wave_a_r;
  logic wave_b_r;
  logic timer_tick;

  t8wm_presc t8wm_presc_inst (
    .clk(clk),
    .nrst(nrst),
    .sel(clksel_r),
    .tick(timer_tick)
  );

  // decode
  logic [1:0] output_a_action;
  logic [1:0] output_b_action;
  logic [2:0] waveform_select;
  logic waveform_select_top_bit;
  logic mode_ccm;
  logic mode_fast;
  logic mode_pc;
  logic mode_pwm;
  logic [7:0] compare_a_value;
  logic [7:0] compare_b_value;
  logic [7:0] top;
  logic at_top;
  logic at_bot;
  logic wr_any;
  logic wr_cnt;
  logic wr_flags;
  logic hit_a;
  logic hit_b;
  logic ovf_ev;
  logic wrap;
  logic up_eff;
  logic wave_a_nxt;
  logic wave_b_nxt;
  logic [7:0] rdata_nxt;

  assign output_a_action = ctrl_r[t8wm_pkg::ACT_A_LSB +: 2];
  assign output_b_action = ctrl_r[t8wm_pkg::ACT_B_LSB +: 2];
  assign waveform_select_top_bit = ctrl_r[t8wm_pkg::SEL_TOP_BIT];
  assign waveform_select = {waveform_select_top_bit, ctrl_r[t8wm_pkg::SEL_LO_LSB +: 2]};
  assign mode_ccm = waveform_select == t8wm_pkg::WS_CLEAR_CMP;
  assign mode_fast = (waveform_select == t8wm_pkg::WS_FAST_FF) ||
                     (waveform_select == t8wm_pkg::WS_FAST_CMP);
  assign mode_pc = (waveform_select == t8wm_pkg::WS_PC_FF) ||
                   (waveform_select == t8wm_pkg::WS_PC_CMP);
  assign mode_pwm = mode_fast || mode_pc;
  // buffered compares only in PWM, direct otherwise
  assign compare_a_value = mode_pwm ? ocr_a_r : buf_a_r;
  assign compare_b_value = mode_pwm ? ocr_b_r : buf_b_r;
  assign top = (mode_ccm || (waveform_select == t8wm_pkg::WS_FAST_CMP) ||
                (waveform_select == t8wm_pkg::WS_PC_CMP)) ? compare_a_value
                                                         : t8wm_pkg::CNT_MAX;
  assign at_top = timer_tick && (count_value_r == top);
  assign at_bot = timer_tick && (count_value_r == t8wm_pkg::CNT_BOTTOM);
  assign wr_any = bus.wr;
  assign wr_cnt = wr_any && (bus.addr == t8wm_pkg::ADDR_COUNT);
  assign wr_flags = wr_any && (bus.addr == t8wm_pkg::ADDR_FLAGS);
  // equality only, so a compare below the count runs on to 0xFF and wraps
  assign hit_a = timer_tick && !blk_r && (count_value_r == compare_a_value);
  assign hit_b = timer_tick && !blk_r && (count_value_r == compare_b_value);
  // fast and clear-on-compare wrap at top, normal and beyond-top at MAX
  // a blocked match in clear-on-compare does not clear the count either
  assign wrap = !mode_pc && timer_tick &&
                ((mode_fast && at_top) || (mode_ccm && hit_a) ||
                 (count_value_r == t8wm_pkg::CNT_MAX));
  assign ovf_ev = mode_pc ? at_bot :
                  mode_fast ? at_top :
                  (timer_tick && (count_value_r == t8wm_pkg::CNT_MAX));
  // bottom counts as upward, top as downward
  assign up_eff = (up_r && (count_value_r != top)) ||
                  (count_value_r == t8wm_pkg::CNT_BOTTOM);

  always_comb begin
    count_value_nxt = count_value_r;
    up_nxt = up_r;
    if (wr_cnt) begin
      count_value_nxt = bus.wdata;
    end else if (timer_tick) begin
      if (mode_pc) begin
        if (up_r) begin
          if (count_value_r >= top) begin
            up_nxt = 1'b0;
            count_value_nxt = count_value_r - 8'h01;
          end else begin
            count_value_nxt = count_value_r + 8'h01;
          end
        end else if (count_value_r == t8wm_pkg::CNT_BOTTOM) begin
          up_nxt = 1'b1;
          count_value_nxt = count_value_r + 8'h01;
        end else begin
          count_value_nxt = count_value_r - 8'h01;
        end
      end else if (wrap) begin
        count_value_nxt = t8wm_pkg::CNT_BOTTOM;
      end else begin
        count_value_nxt = count_value_r + 8'h01;
      end
    end
  end

  function automatic logic wave_fn(input logic cur, input logic [1:0] act,
                                   input logic chan_a, input logic top_bit,
                                   input logic fast, input logic pc,
                                   input logic m, input logic wr_top,
                                   input logic bot, input logic up,
                                   input logic top_eq);
    logic r;
    r = cur;
    if (fast || pc) begin
      if (act == t8wm_pkg::ACT_TOGGLE) begin
        if (chan_a && top_bit && m) begin
          r = ~cur;
        end
      end else if (act[1]) begin
        if (fast) begin
          if (wr_top) begin
            r = ~act[0];
          end else if (m) begin
            r = act[0];
          end
        end else begin
          if (wr_top && top_eq) begin
            r = ~act[0];
          end else if (m) begin
            r = up ? act[0] : ~act[0];
          end else if (bot) begin
            r = ~act[0];
          end
        end
      end
    end else if (m) begin
      case (act)
        t8wm_pkg::ACT_TOGGLE: r = ~cur;
        t8wm_pkg::ACT_CLEAR: r = 1'b0;
        t8wm_pkg::ACT_SET: r = 1'b1;
        default: r = cur;
      endcase
    end
    return r;
  endfunction : wave_fn

  assign wave_a_nxt = wave_fn(wave_a_r, output_a_action, 1'b1, waveform_select_top_bit,
                              mode_fast, mode_pc, hit_a, at_top, at_bot, up_eff,
                              compare_a_value == top);
  assign wave_b_nxt = wave_fn(wave_b_r, output_b_action, 1'b0, waveform_select_top_bit,
                              mode_fast, mode_pc, hit_b, at_top, at_bot, up_eff,
                              compare_b_value == top);

  // fast reloads compares at bottom, phase correct at top
  logic upd;
  assign upd = mode_fast ? wrap : (mode_pc && at_top);

  assign rdata_nxt = !bus.rd ? 8'h00 :
    (bus.addr == t8wm_pkg::ADDR_CTRL) ? ctrl_r :
    (bus.addr == t8wm_pkg::ADDR_CLKSEL) ? {5'h00, clksel_r} :
    (bus.addr == t8wm_pkg::ADDR_COUNT) ? count_value_r :
    (bus.addr == t8wm_pkg::ADDR_CMP_A) ? buf_a_r :
    (bus.addr == t8wm_pkg::ADDR_CMP_B) ? buf_b_r :
    (bus.addr == t8wm_pkg::ADDR_FLAGS) ?
      {5'h00, match_b_flag, match_a_flag, overflow_flag} :
    (bus.addr == t8wm_pkg::ADDR_PIN_DIR) ? {6'h00, dir_r} : {6'h00, port_r};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_r <= 8'h00;
      clksel_r <= 3'h0;
      dir_r <= 2'h0;
      port_r <= 2'h0;
    end else if (wr_any) begin
      if (bus.addr == t8wm_pkg::ADDR_CTRL) ctrl_r <= bus.wdata;
      if (bus.addr == t8wm_pkg::ADDR_CLKSEL) clksel_r <= bus.wdata[2:0];
      if (bus.addr == t8wm_pkg::ADDR_PIN_DIR) dir_r <= bus.wdata[1:0];
      if (bus.addr == t8wm_pkg::ADDR_PIN_DATA) port_r <= bus.wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      buf_a_r <= 8'h00;
      buf_b_r <= 8'h00;
      ocr_a_r <= 8'h00;
      ocr_b_r <= 8'h00;
    end else begin
      if (wr_any && (bus.addr == t8wm_pkg::ADDR_CMP_A)) buf_a_r <= bus.wdata;
      if (wr_any && (bus.addr == t8wm_pkg::ADDR_CMP_B)) buf_b_r <= bus.wdata;
      if (!mode_pwm || upd) begin
        ocr_a_r <= buf_a_r;
        ocr_b_r <= buf_b_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      count_value_r <= 8'h00;
      up_r <= 1'b1;
      blk_r <= 1'b0;
      wave_a_r <= 1'b0;
      wave_b_r <= 1'b0;
    end else begin
      count_value_r <= count_value_nxt;
      up_r <= up_nxt;
      blk_r <= wr_cnt || (blk_r && !timer_tick);
      wave_a_r <= wave_a_nxt;
      wave_b_r <= wave_b_nxt;
    end
  end

  // hardware set wins over software clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      overflow_flag <= 1'b0;
      match_a_flag <= 1'b0;
      match_b_flag <= 1'b0;
    end else begin
      overflow_flag <= ovf_ev || (overflow_flag && !(wr_flags && bus.wdata[t8wm_pkg::FLAG_OVF]));
      match_a_flag <= hit_a || (match_a_flag && !(wr_flags && bus.wdata[t8wm_pkg::FLAG_MA]));
      match_b_flag <= hit_b || (match_b_flag && !(wr_flags && bus.wdata[t8wm_pkg::FLAG_MB]));
    end
  end

  // pin drive: wave when action set, port bit otherwise
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_a <= '0;
      pin_b <= '0;
      rdata <= 8'h00;
    end else begin
      pin_a.o <= (output_a_action != t8wm_pkg::ACT_OFF) ? wave_a_nxt : port_r[0];
      pin_b.o <= (output_b_action != t8wm_pkg::ACT_OFF) ? wave_b_nxt : port_r[1];
      pin_a.oe <= dir_r[0];
      pin_b.oe <= dir_r[1];
      rdata <= rdata_nxt;
    end
  end

  ccm_wrap_a: assert property (@(posedge clk) disable iff (!nrst)
    (mode_ccm && hit_a && !wr_cnt) |=> (count_value_r == t8wm_pkg::CNT_BOTTOM))
    else $error("count not cleared at compare");
  flag_match_a: assert property (@(posedge clk) disable iff (!nrst)
    (hit_a) |=> match_a_flag)
    else $error("match flag not raised");
  ccm_toggle_a: assert property (@(posedge clk) disable iff (!nrst)
    (mode_ccm && hit_a && output_a_action == t8wm_pkg::ACT_TOGGLE) |=>
    (wave_a_r != $past(wave_a_r)))
    else $error("output a did not toggle");
  fast_wrap_a: assert property (@(posedge clk) disable iff (!nrst)
    (mode_fast && at_top && !wr_cnt) |=>
    (count_value_r == t8wm_pkg::CNT_BOTTOM) && overflow_flag)
    else $error("fast wrap or overflow missing");
  pc_turn_a: assert property (@(posedge clk) disable iff (!nrst)
    (mode_pc && at_top && up_r && !wr_cnt && top != 8'h00) |=> !up_r
    && (count_value_r == $past(count_value_r) - 8'h01))
    else $error("phase mode did not turn at top");
  pc_ovf_a: assert property (@(posedge clk) disable iff (!nrst)
    (mode_pc && at_bot) |=> overflow_flag)
    else $error("bottom overflow missing");
  match_block_a: assert property (@(posedge clk) disable iff (!nrst)
    (blk_r && timer_tick && !match_a_flag) |=> !match_a_flag)
    else $error("match not blocked after count write");
  pin_dir_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_any && bus.addr == t8wm_pkg::ADDR_PIN_DIR) |=> ##1
    (pin_a.oe == $past(bus.wdata[0], 2)))
    else $error("pin enable not following direction");
  ccm_direct_a: assert property (@(posedge clk) disable iff (!nrst)
    (mode_ccm && wr_any && bus.addr == t8wm_pkg::ADDR_CMP_A) |=>
    (compare_a_value == $past(bus.wdata)))
    else $error("compare a not applied at once");
  ccm_ovf_a: assert property (@(posedge clk) disable iff (!nrst)
    (mode_ccm && timer_tick && count_value_r == t8wm_pkg::CNT_MAX) |=> overflow_flag)
    else $error("overflow missing at wrap");
  buf_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (mode_pwm && !upd) |=> $stable(ocr_a_r))
    else $error("compare a changed mid period");
  pin_off_a: assert property (@(posedge clk) disable iff (!nrst)
    (output_a_action == t8wm_pkg::ACT_OFF) |=> (pin_a.o == $past(port_r[0])))
    else $error("pin a not back on port data");
  b_no_toggle_a: assert property (@(posedge clk) disable iff (!nrst)
    (mode_pwm && output_b_action == t8wm_pkg::ACT_TOGGLE) |=> $stable(wave_b_r))
    else $error("output b toggled in pwm");
  pc_bottom_a: assert property (@(posedge clk) disable iff (!nrst)
    (mode_pc && at_bot && !wr_cnt && top != t8wm_pkg::CNT_BOTTOM) |=>
    up_r && (count_value_r == $past(count_value_r) + 8'h01))
    else $error("phase mode did not turn at bottom");
  fast_up_a: assert property (@(posedge clk) disable iff (!nrst)
    (mode_fast && timer_tick && !at_top && !wr_cnt && count_value_r != t8wm_pkg::CNT_MAX)
    |=> (count_value_r == $past(count_value_r) + 8'h01))
    else $error("fast count not rising");
  pc_ext_a: assert property (@(posedge clk) disable iff (!nrst)
    (mode_pc && output_a_action[1] && at_top && compare_a_value == top) |=>
    (wave_a_r == !$past(output_a_action[0])))
    else $error("phase extreme level wrong");
  reset_clr_a: assert property (@(posedge clk)
    (!nrst) |=> (count_value_r == 8'h00 && !overflow_flag && !wave_a_r && up_r))
    else $error("reset state wrong");
endmodule : t8wm_core

// [test/t8wm_core_tb.sv]
`timescale 1ns/1ps
module t8wm_core_tb;
  logic clk;
  logic nrst;
  t8wm_pkg::t8wm_bus_t bus;
  logic [7:0] rdata;
  t8wm_pkg::t8wm_pin_t pin_a;
  t8wm_pkg::t8wm_pin_t pin_b;
  logic overflow_flag;
  logic match_a_flag;
  logic match_b_flag;
  int mismatches;
  int tests_run;
  int k;
  int fac[5] = '{1, 8, 64, 256, 1024};
  logic [15:0] rnd;
  logic [15:0] ha;
  logic [15:0] hb;
  logic [7:0] d;
  logic [7:0] c;
  logic [7:0] cb;
  logic [1:0] aa;
  logic [1:0] ab;

  t8wm_core t8wm_core_inst (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata),
    .pin_a(pin_a), .pin_b(pin_b), .overflow_flag(overflow_flag),
    .match_a_flag(match_a_flag), .match_b_flag(match_b_flag));

  always #25 clk = ~clk;

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  function automatic logic [7:0] ctrl(input logic [1:0] a, input logic [1:0] b,
    input logic [2:0] ws);
    ctrl = {a, b, ws[2], 1'b0, ws[1:0]};
  endfunction : ctrl

  // high ticks per 256-tick period
  function automatic logic [15:0] fast_hi(input logic [1:0] act, input logic [7:0] v);
    fast_hi = (act == 2'h2) ? {8'h00, v} + 16'h0001 : 16'h00ff - {8'h00, v};
  endfunction : fast_hi

  // high ticks per 510-tick period
  function automatic logic [15:0] pc_hi(input logic [1:0] act, input logic [7:0] v);
    pc_hi = (act == 2'h2) ? {7'h00, v, 1'b0} : 16'h01fe - {7'h00, v, 1'b0};
  endfunction : pc_hi

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd

  task automatic edge_wait();
    logic p;
    @(posedge clk);
    #1 p = pin_a.o;
    k = 1;
    while (pin_a.o === p && k < 5000) begin
      @(posedge clk);
      #1 k++;
    end
    if (k >= 5000) begin
      mismatches++;
      results();
    end
  endtask : edge_wait

  // cycles between two later edges of output a
  task automatic gap();
    edge_wait();
    edge_wait();
    edge_wait();
  endtask : gap

  task automatic duty(input int win);
    ha = 16'h0000;
    hb = 16'h0000;
    repeat (win) begin
      @(posedge clk);
      #1 ha = ha + {15'h0000, pin_a.o};
      hb = hb + {15'h0000, pin_b.o};
    end
  endtask : duty

  task automatic setup(input logic [7:0] ct, input logic [7:0] va, input logic [7:0] vb,
    input logic [2:0] cs);
    wr(t8wm_pkg::ADDR_CLKSEL, 8'h00);
    wr(t8wm_pkg::ADDR_COUNT, 8'h00);
    wr(t8wm_pkg::ADDR_CTRL, ct);
    wr(t8wm_pkg::ADDR_CMP_A, va);
    wr(t8wm_pkg::ADDR_CMP_B, vb);
    wr(t8wm_pkg::ADDR_FLAGS, 8'h07);
    wr(t8wm_pkg::ADDR_CLKSEL, {5'h00, cs});
  endtask : setup

  // counter preset, compare rewritten while running, then first match awaited
  task automatic wrap_case(input logic [7:0] cv, input logic [7:0] av,
    input logic [7:0] nv, input logic ov);
    int n;
    wr(t8wm_pkg::ADDR_CLKSEL, 8'h00);
    wr(t8wm_pkg::ADDR_CTRL, ctrl(2'h0, 2'h0, t8wm_pkg::WS_CLEAR_CMP));
    wr(t8wm_pkg::ADDR_CMP_A, av);
    wr(t8wm_pkg::ADDR_COUNT, cv);
    wr(t8wm_pkg::ADDR_FLAGS, 8'h07);
    wr(t8wm_pkg::ADDR_CLKSEL, {5'h00, t8wm_pkg::CS_DIV1});
    wr(t8wm_pkg::ADDR_CMP_A, nv);
    n = 0;
    while (match_a_flag !== 1'b1 && n < 600) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 600) begin
      mismatches++;
      results();
    end
    chk_val({7'h00, overflow_flag}, {7'h00, ov});
  endtask : wrap_case

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    bus = '0;
    mismatches = 0;
    tests_run = 0;
    rnd = 16'h0621;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk_val({1'b0, pin_a, pin_b, overflow_flag, match_a_flag, match_b_flag}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), d);
      chk_val(d, 8'h00);
    end
    wr(t8wm_pkg::ADDR_PIN_DIR, 8'h01);
    wr(t8wm_pkg::ADDR_PIN_DATA, 8'h02);
    rd(t8wm_pkg::ADDR_PIN_DIR, d);
    chk_val(d, 8'h01);
    chk_val({4'h0, pin_a.oe, pin_b.oe, pin_a.o, pin_b.o}, 8'h09);
    wr(t8wm_pkg::ADDR_PIN_DIR, 8'h03);
    for (int i = 0; i < 5; i++) begin
      c = (i == 0) ? {4'h0, rnd[3:0]} : 8'h01;
      rnd = lfsr(rnd);
      setup(ctrl(2'h1, 2'h0, t8wm_pkg::WS_CLEAR_CMP), c, 8'h00, 3'(i + 1));
      gap();
      chk_cnt(16'(k), 16'(fac[i] * (int'(c) + 1)));
      chk_val({7'h00, match_a_flag}, 8'h01);
      rd(t8wm_pkg::ADDR_COUNT, d);
      chk_val({7'h00, d <= c}, 8'h01);
    end
    wrap_case(8'h0a, 8'h32, 8'h32, 1'b0);
    wrap_case(8'h64, 8'hc8, 8'h32, 1'b1);
    wrap_case(8'h28, 8'h28, 8'h28, 1'b1);
    for (int i = 0; i < 4; i++) begin
      c = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd[7:0];
      cb = rnd[15:8];
      aa = {1'b1, i[0]};
      ab = {1'b1, rnd[1]};
      rnd = lfsr(rnd);
      setup(ctrl(aa, ab, t8wm_pkg::WS_FAST_FF), c, cb, t8wm_pkg::CS_DIV1);
      repeat (600) @(posedge clk);
      duty(256);
      chk_cnt(ha, fast_hi(aa, c));
      chk_cnt(hb, fast_hi(ab, cb));
      chk_val({7'h00, overflow_flag}, 8'h01);
      setup(ctrl(aa, ab, t8wm_pkg::WS_PC_FF), c, cb, t8wm_pkg::CS_DIV1);
      repeat (1100) @(posedge clk);
      duty(510);
      chk_cnt(ha, pc_hi(aa, c));
      chk_cnt(hb, pc_hi(ab, cb));
      chk_val({7'h00, overflow_flag}, 8'h01);
    end
    c = 8'h10 + {4'h0, rnd[3:0]};
    setup(ctrl(2'h1, 2'h1, t8wm_pkg::WS_FAST_CMP), c, 8'h05, t8wm_pkg::CS_DIV1);
    gap();
    chk_cnt(16'(k), {8'h00, c} + 16'h0001);
    duty(64);
    chk_val({7'h00, hb == 16'h0000 || hb == 16'h0040}, 8'h01);
    setup(ctrl(2'h1, 2'h0, t8wm_pkg::WS_PC_CMP), c, 8'h05, t8wm_pkg::CS_DIV1);
    gap();
    chk_cnt(16'(k), {7'h00, c, 1'b0});
    results();
  end
endmodule : t8wm_core_tb
